/* File: logic/scpm_port.sv */
// SMBus target with PLL mode strap capture and software override
`timescale 1ns/10ps
module scpm_port import scpm_pkg::*; (
  // System clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // Serial bus
  input  wire logic       scl_clk_in,
  input  wire logic       serial_data_pin_in,
  output logic            serial_data_pin_out,
  output logic            serial_data_pin_oe_out,
  // Straps and power
  input  wire logic       power_good_input_in,
  input  wire logic [1:0] pll_bandwidth_strap_in,
  input  wire logic [1:0] address_strap_low_in,
  input  wire logic [1:0] address_strap_high_in,
  input  wire logic       freq_select_strap_in,
  // PLL control
  output logic            pll_bypass_out,
  output logic            pll_engage_out,
  output logic            wide_loop_mode_out,
  output logic            narrow_loop_mode_out,
  output logic            power_down_n_out
);
  // ==========================================================
  // Declarations
  logic [1:0] bus_s, bus_d_reg, bus_f_reg, bus_p_reg;
  logic [7:0] strap_s;
  logic [1:0] tgl_s;
  logic       wr_seen_reg, idx_seen_reg, wr_fire, idx_fire;
  logic       start_det, stop_det;
  logic       idle_reg, frame_rst_reg, cmd_rst_reg, hard_rst_reg;
  logic [2:0] start_cnt_reg;
  logic       latched_reg, power_down_reg, latch_now;
  scpm_code_t strap_code_reg, ovr_reg, pll_mode_reg, eff_mode;
  logic [6:0] own_addr_reg, own_addr_l;
  logic       freq_rb_reg, ctrl_en_reg;
  scpm_idx_t  sys_idx_reg;
  logic [7:0] mem_q, rd_data_reg, byte0, addr_full;
  logic       sda_out_reg, bypass_reg, engage_reg, wide_reg, narrow_reg, pwr_n_reg;
  scpm_link_e state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg, tx_reg, count_reg, wr_data_reg, byte_now;
  logic       ack_reg, is_read_reg, tx_is_count_reg, byte_mode_reg, sda_oe_reg;
  logic       idx_tgl_reg, wr_tgl_reg, byte_end, ack_slot, addr_match;
  scpm_idx_t  index_reg, wr_idx_reg;

  // ==========================================================
  // Synchronisers
  scpm_sync #(.W(2)) u_bus_sync (
    .clk_in (ref_clk_in),
    .d_in   ({scl_clk_in, serial_data_pin_in}),
    .q_out  (bus_s)
  );
  scpm_sync #(.W(8)) u_strap_sync (
    .clk_in (ref_clk_in),
    .d_in   ({power_good_input_in, pll_bandwidth_strap_in, address_strap_high_in,
              address_strap_low_in, freq_select_strap_in}),
    .q_out  (strap_s)
  );
  scpm_sync #(.W(2)) u_tgl_sync (
    .clk_in (ref_clk_in),
    .d_in   ({wr_tgl_reg, idx_tgl_reg}),
    .q_out  (tgl_s)
  );
  // Address is static after latching, so a level crossing is enough
  scpm_sync #(.W(7)) u_addr_sync (
    .clk_in (scl_clk_in),
    .d_in   (own_addr_reg),
    .q_out  (own_addr_l)
  );

  // ==========================================================
  // Input filter and start/stop detection
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      bus_d_reg <= 2'h3;
      bus_f_reg <= 2'h3;
      bus_p_reg <= 2'h3;
    end else begin
      bus_d_reg <= bus_s;
      bus_f_reg <= (bus_s & bus_d_reg) | (bus_f_reg & (bus_s | bus_d_reg));
      bus_p_reg <= bus_f_reg;
    end
  end

  assign start_det = bus_f_reg[1] & bus_p_reg[1] & bus_p_reg[0] & ~bus_f_reg[0];
  assign stop_det  = bus_f_reg[1] & bus_p_reg[1] & ~bus_p_reg[0] & bus_f_reg[0];

  // Link resets: start clears framing, stop also clears the command
  always_ff @(posedge ref_clk_in) begin
    hard_rst_reg <= sys_rst_in;
    if (sys_rst_in) begin
      idle_reg      <= 1'b1;
      start_cnt_reg <= 3'h0;
      frame_rst_reg <= 1'b1;
      cmd_rst_reg   <= 1'b1;
    end else begin
      if (stop_det || power_down_reg) begin
        idle_reg <= 1'b1;
      end else if (start_det) begin
        idle_reg <= 1'b0;
      end
      start_cnt_reg <= start_det ? `SCPM_START_RST_CYC :
                       (start_cnt_reg != 3'h0) ? start_cnt_reg - 3'h1 : 3'h0;
      frame_rst_reg <= idle_reg | power_down_reg | start_det | (start_cnt_reg != 3'h0);
      cmd_rst_reg   <= idle_reg | power_down_reg;
    end
  end

  // ==========================================================
  // Strap capture and power down
  assign latch_now = strap_s[7] && !latched_reg;
  assign addr_full = scpm_addr_lookup(strap_s[4:3], strap_s[2:1]);

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      latched_reg    <= 1'b0;
      power_down_reg <= 1'b1;
      strap_code_reg <= `SCPM_CODE_NARROW;
      own_addr_reg   <= 7'h00;
      freq_rb_reg    <= 1'b0;
    end else begin
      power_down_reg <= !(latched_reg && strap_s[7]);
      if (latch_now) begin
        latched_reg    <= 1'b1;
        strap_code_reg <= scpm_decode_level(strap_s[6:5]);
        own_addr_reg   <= addr_full[7:1];
        freq_rb_reg    <= strap_s[0];
      end
    end
  end

  // ==========================================================
  // Write and index handshakes from the link
  assign wr_fire  = tgl_s[1] != wr_seen_reg;
  assign idx_fire = tgl_s[0] != idx_seen_reg;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      wr_seen_reg  <= 1'b0;
      idx_seen_reg <= 1'b0;
    end else begin
      wr_seen_reg  <= tgl_s[1];
      idx_seen_reg <= tgl_s[0];
    end
  end

  // Override starts equal to the strap so enabling it alone changes nothing
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ctrl_en_reg <= 1'b0;
      ovr_reg     <= `SCPM_CODE_NARROW;
    end else if (latch_now) begin
      ovr_reg <= scpm_decode_level(strap_s[6:5]);
    end else if (wr_fire && wr_idx_reg == `SCPM_REG_MODE_CTRL) begin
      ctrl_en_reg <= wr_data_reg[`SCPM_OVR_EN_BIT];
      if (ctrl_en_reg) begin
        ovr_reg <= wr_data_reg[`SCPM_OVR_HI:`SCPM_OVR_LO];
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in || cmd_rst_reg) begin
      sys_idx_reg <= `SCPM_REG_MODE_CTRL;
    end else if (idx_fire) begin
      sys_idx_reg <= index_reg;
    end
  end

  scpm_regmem u_mem (
    .ref_clk_in  (ref_clk_in),
    .sys_rst_in  (sys_rst_in),
    .wr_en_in    (wr_fire && wr_idx_reg != `SCPM_REG_MODE_CTRL && scpm_in_map(wr_idx_reg)),
    .wr_addr_in  (wr_idx_reg[2:0]),
    .wr_data_in  (wr_data_reg),
    .rd_addr_in  (sys_idx_reg[2:0]),
    .rd_data_out (mem_q)
  );

  // Readback bits 7:6 keep the latched strap, never the override
  assign byte0 = {strap_code_reg, `SCPM_CTRL_RSV, ctrl_en_reg, ovr_reg, freq_rb_reg};

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_data_reg <= 8'h00;
    end else if (sys_idx_reg == `SCPM_REG_MODE_CTRL) begin
      rd_data_reg <= byte0;
    end else begin
      rd_data_reg <= scpm_in_map(sys_idx_reg) ? mem_q : 8'h00;
    end
  end

  // ==========================================================
  // PLL mode outputs; new mode needs a warm reset to be relied on
  assign eff_mode = ctrl_en_reg ? ovr_reg : strap_code_reg;

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      pll_mode_reg <= `SCPM_CODE_NARROW;
      bypass_reg   <= 1'b0;
      engage_reg   <= 1'b1;
      wide_reg     <= 1'b0;
      narrow_reg   <= 1'b1;
      pwr_n_reg    <= 1'b0;
      sda_out_reg  <= 1'b0;
    end else begin
      pll_mode_reg <= eff_mode;
      bypass_reg   <= eff_mode == `SCPM_CODE_BYPASS;
      engage_reg   <= eff_mode != `SCPM_CODE_BYPASS;
      wide_reg     <= eff_mode[1];
      narrow_reg   <= eff_mode == `SCPM_CODE_NARROW;
      pwr_n_reg    <= !power_down_reg;
      sda_out_reg  <= 1'b0;
    end
  end

  // ==========================================================
  // Link side, clocked by the bus clock; never drives the clock line
  assign byte_now   = {shift_reg[6:0], serial_data_pin_in};
  assign byte_end   = bit_cnt_reg == `SCPM_BIT_LAST;
  assign ack_slot   = bit_cnt_reg == `SCPM_BIT_ACK;
  assign addr_match = byte_now[7:1] == own_addr_l && byte_now[7:1] != 7'h00;

  always_ff @(posedge scl_clk_in or posedge frame_rst_reg) begin
    if (frame_rst_reg) begin
      state_reg       <= LK_ADDR;
      bit_cnt_reg     <= 4'h0;
      shift_reg       <= 8'h00;
      tx_reg          <= 8'hFF;
      ack_reg         <= 1'b0;
      is_read_reg     <= 1'b0;
      tx_is_count_reg <= 1'b0;
    end else if (!ack_slot) begin
      shift_reg   <= byte_now;
      bit_cnt_reg <= bit_cnt_reg + 4'h1;
      if (state_reg == LK_RDATA) begin
        tx_reg <= {tx_reg[6:0], 1'b1};
      end
      if (byte_end) begin
        unique case (state_reg)
          LK_ADDR: begin
            ack_reg     <= addr_match;
            is_read_reg <= byte_now[0];
          end
          LK_CMD, LK_COUNT, LK_WDATA: ack_reg <= 1'b1;
          LK_RDATA, LK_IDLE:          ack_reg <= 1'b0;
        endcase
      end
    end else begin
      bit_cnt_reg <= 4'h0;
      ack_reg     <= 1'b0;
      unique case (state_reg)
        LK_ADDR: begin
          if (!ack_reg) begin
            state_reg <= LK_IDLE;
          end else if (is_read_reg) begin
            state_reg       <= LK_RDATA;
            tx_reg          <= byte_mode_reg ? rd_data_reg : `SCPM_BLOCK_RD_COUNT;
            tx_is_count_reg <= !byte_mode_reg;
          end else begin
            state_reg <= LK_CMD;
          end
        end
        LK_CMD:   state_reg <= byte_mode_reg ? LK_WDATA : LK_COUNT;
        LK_COUNT: state_reg <= LK_WDATA;
        LK_WDATA: state_reg <= byte_mode_reg ? LK_IDLE : LK_WDATA;
        LK_RDATA: begin
          if (serial_data_pin_in) begin
            state_reg <= LK_IDLE;
          end else begin
            tx_reg          <= rd_data_reg;
            tx_is_count_reg <= 1'b0;
          end
        end
        LK_IDLE: state_reg <= LK_IDLE;
      endcase
    end
  end

  // Command survives a repeated start, cleared only by stop, power down or system reset
  always_ff @(posedge scl_clk_in or posedge cmd_rst_reg) begin
    if (cmd_rst_reg) begin
      index_reg     <= `SCPM_REG_MODE_CTRL;
      byte_mode_reg <= 1'b1;
      count_reg     <= 8'h00;
      idx_tgl_reg   <= 1'b0;
    end else if (byte_end) begin
      if (state_reg == LK_CMD) begin
        byte_mode_reg <= byte_now[7];
        index_reg     <= byte_now[6:0];
        idx_tgl_reg   <= !idx_tgl_reg;
      end else if (state_reg == LK_COUNT) begin
        count_reg <= byte_now;
      end else if (!byte_mode_reg && (state_reg == LK_WDATA ||
                   (state_reg == LK_RDATA && !tx_is_count_reg))) begin
        index_reg   <= index_reg + 7'h01;
        idx_tgl_reg <= !idx_tgl_reg;
        if (state_reg == LK_WDATA && count_reg != 8'h00) begin
          count_reg <= count_reg - 8'h01;
        end
      end
    end
  end

  // Bytes past the count are acknowledged but dropped
  always_ff @(posedge scl_clk_in or posedge hard_rst_reg) begin
    if (hard_rst_reg) begin
      wr_tgl_reg  <= 1'b0;
      wr_data_reg <= 8'h00;
      wr_idx_reg  <= `SCPM_REG_MODE_CTRL;
    end else if (byte_end && state_reg == LK_WDATA && (byte_mode_reg || count_reg != 8'h00)) begin
      wr_data_reg <= byte_now;
      wr_idx_reg  <= index_reg;
      wr_tgl_reg  <= !wr_tgl_reg;
    end
  end

  // Data changes on the falling edge, clear of the sampling edge
  always_ff @(negedge scl_clk_in or posedge frame_rst_reg) begin
    if (frame_rst_reg) begin
      sda_oe_reg <= 1'b0;
    end else begin
      sda_oe_reg <= (ack_slot && ack_reg) || (state_reg == LK_RDATA && !ack_slot && !tx_reg[7]);
    end
  end

  assign serial_data_pin_out    = sda_out_reg;
  assign serial_data_pin_oe_out = sda_oe_reg;
  assign pll_bypass_out         = bypass_reg;
  assign pll_engage_out         = engage_reg;
  assign wide_loop_mode_out     = wide_reg;
  assign narrow_loop_mode_out   = narrow_reg;
  assign power_down_n_out       = pwr_n_reg;

  // ==========================================================
  // Checks
  sequence s_wbyte_end;
    state_reg == LK_WDATA && bit_cnt_reg == `SCPM_BIT_LAST;
  endsequence

  a_strap_decode: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    latch_now |=> strap_code_reg == scpm_decode_level($past(strap_s[6:5])))
    else $error("strap decode wrong");
  a_readback_code: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    sys_idx_reg == `SCPM_REG_MODE_CTRL && $stable(sys_idx_reg) |=> rd_data_reg[7:6] == $past(strap_code_reg))
    else $error("readback not strap");
  a_bypass_route: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !ctrl_en_reg && strap_code_reg == `SCPM_CODE_BYPASS |=> pll_bypass_out && !pll_engage_out)
    else $error("bypass not routed");
  a_pll_route: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ctrl_en_reg && ovr_reg != `SCPM_CODE_BYPASS |=> pll_engage_out && !pll_bypass_out)
    else $error("pll not engaged");
  a_override_use: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    ctrl_en_reg ##1 ctrl_en_reg |-> pll_mode_reg == $past(ovr_reg))
    else $error("override ignored");
  a_override_gate: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    !latch_now && !ctrl_en_reg |=> ovr_reg == $past(ovr_reg))
    else $error("override changed while locked");
  a_pd_release: assert property (@(posedge ref_clk_in) disable iff (sys_rst_in)
    power_down_reg |=> ##1 frame_rst_reg ##1 !serial_data_pin_oe_out)
    else $error("data not released");
  a_no_general: assert property (@(posedge scl_clk_in) disable iff (frame_rst_reg)
    state_reg == LK_ADDR && byte_end && byte_now[7:1] == 7'h00 |=> !ack_reg)
    else $error("general call acked");
  a_count_next: assert property (@(posedge scl_clk_in) disable iff (frame_rst_reg)
    state_reg == LK_CMD && ack_slot && !byte_mode_reg |=> state_reg == LK_COUNT)
    else $error("count phase skipped");
  a_block_ack: assert property (@(posedge scl_clk_in) disable iff (frame_rst_reg)
    s_wbyte_end |=> ack_reg && ack_slot)
    else $error("write byte not acked");
  a_index_step: assert property (@(posedge scl_clk_in) disable iff (cmd_rst_reg)
    s_wbyte_end and !byte_mode_reg |=> index_reg == $past(index_reg) + 7'h01)
    else $error("index not advanced");
endmodule : scpm_port

/* File: logic/scpm_regs.svh */
// Register map, field positions and constants of the SMBus mode port
`ifndef SCPM_REGS_SVH
`define SCPM_REGS_SVH

// ==========================================================
// Register map
`define SCPM_REG_MODE_CTRL   7'h00
`define SCPM_REG_DEPTH       7'h08
`define SCPM_BLOCK_RD_COUNT  8'h08

// ==========================================================
// Control byte zero fields
`define SCPM_RB_HI           7
`define SCPM_RB_LO           6
`define SCPM_OVR_EN_BIT      3
`define SCPM_OVR_HI          2
`define SCPM_OVR_LO          1
`define SCPM_FREQ_RB_BIT     0
`define SCPM_CTRL_RSV        2'h0

// ==========================================================
// Mode codes and strap levels
`define SCPM_CODE_NARROW     2'h0
`define SCPM_CODE_BYPASS     2'h1
`define SCPM_CODE_WIDE       2'h3
`define SCPM_LVL_LOW         2'h0
`define SCPM_LVL_MID         2'h1
`define SCPM_LVL_HIGH        2'h3

// ==========================================================
// Bus addresses, eight-bit form
`define SCPM_ADDR_LL         8'hD8
`define SCPM_ADDR_LM         8'hDA
`define SCPM_ADDR_LH         8'hDE
`define SCPM_ADDR_ML         8'hC2
`define SCPM_ADDR_MM         8'hC4
`define SCPM_ADDR_MH         8'hC6
`define SCPM_ADDR_HL         8'hCA
`define SCPM_ADDR_HM         8'hCC
`define SCPM_ADDR_HH         8'hCE

// ==========================================================
// Link timing
`define SCPM_BIT_LAST        4'h7
`define SCPM_BIT_ACK         4'h8
`define SCPM_START_RST_CYC   3'h4

`endif

/* File: logic/scpm_pkg.sv */
// Types and decode functions of the SMBus mode port
package scpm_pkg;
  `include "scpm_regs.svh"

  typedef enum logic [2:0] {LK_ADDR, LK_CMD, LK_COUNT, LK_WDATA, LK_RDATA, LK_IDLE} scpm_link_e;
  typedef logic [1:0] scpm_code_t;
  typedef logic [6:0] scpm_idx_t;

  // Three-level pin to mode code; unknown level falls to wide loop
  function automatic scpm_code_t scpm_decode_level(input logic [1:0] lvl);
    unique case (lvl)
      `SCPM_LVL_LOW: scpm_decode_level = `SCPM_CODE_NARROW;
      `SCPM_LVL_MID: scpm_decode_level = `SCPM_CODE_BYPASS;
      default:       scpm_decode_level = `SCPM_CODE_WIDE;
    endcase
  endfunction : scpm_decode_level

  function automatic logic [7:0] scpm_addr_lookup(input logic [1:0] hi, input logic [1:0] lo);
    logic [3:0] key;
    key = {scpm_decode_level(hi), scpm_decode_level(lo)};
    unique case (key)
      4'h0:    scpm_addr_lookup = `SCPM_ADDR_LL;
      4'h1:    scpm_addr_lookup = `SCPM_ADDR_LM;
      4'h3:    scpm_addr_lookup = `SCPM_ADDR_LH;
      4'h4:    scpm_addr_lookup = `SCPM_ADDR_ML;
      4'h5:    scpm_addr_lookup = `SCPM_ADDR_MM;
      4'h7:    scpm_addr_lookup = `SCPM_ADDR_MH;
      4'hC:    scpm_addr_lookup = `SCPM_ADDR_HL;
      4'hD:    scpm_addr_lookup = `SCPM_ADDR_HM;
      default: scpm_addr_lookup = `SCPM_ADDR_HH;
    endcase
  endfunction : scpm_addr_lookup

  function automatic logic scpm_in_map(input scpm_idx_t idx);
    scpm_in_map = (idx < `SCPM_REG_DEPTH);
  endfunction : scpm_in_map
endpackage : scpm_pkg

/* File: logic/scpm_sync.sv */
// Two-stage synchroniser for levels and toggles
`timescale 1ns/10ps
module scpm_sync #(
  parameter int W = 1
) (
  // Destination clock
  input  wire logic         clk_in,
  // Data
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] hold_reg;

  always_ff @(posedge clk_in) begin
    meta_reg <= d_in;
    hold_reg <= meta_reg;
  end

  assign q_out = hold_reg;
endmodule : scpm_sync

/* File: logic/scpm_regmem.sv */
// Register storage behind control byte zero, registered read port
`timescale 1ns/10ps
module scpm_regmem import scpm_pkg::*; (
  // Clock and reset
  input  wire logic       ref_clk_in,
  input  wire logic       sys_rst_in,
  // Write port
  input  wire logic       wr_en_in,
  input  wire logic [2:0] wr_addr_in,
  input  wire logic [7:0] wr_data_in,
  // Read port
  input  wire logic [2:0] rd_addr_in,
  output logic      [7:0] rd_data_out
);
  logic [7:0] mem_reg [`SCPM_REG_DEPTH];
  logic [7:0] rd_reg;

  // Only system reset clears; power down keeps contents
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      for (int i = 0; i < `SCPM_REG_DEPTH; i++) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      rd_reg <= 8'h00;
    end else begin
      rd_reg <= mem_reg[rd_addr_in];
    end
  end

  assign rd_data_out = rd_reg;
endmodule : scpm_regmem

/* File: tb/scpm_host.sv */
// SMBus host controller model: bus clock and open-drain data
`timescale 1ns/10ps
module scpm_host (
  // Bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_low_out
);
  // ==========================================================
  // Standard-mode bit timing, 100 ns per phase
  localparam int Q = 100;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
  end

  // Clock stands high between frames; data bits change only while clock is low, start and stop change data while it is high
  task automatic clk_bit(input logic lo, output logic seen);
    sda_low_out = lo;
    #Q scl_out = 1'b1;
    #Q seen = sda_in;
    #Q scl_out = 1'b0;
    #Q;
  endtask : clk_bit

  task automatic start;
    sda_low_out = 1'b0;
    #Q scl_out = 1'b1;
    #(2*Q) sda_low_out = 1'b1;
    #(2*Q) scl_out = 1'b0;
    #Q;
  endtask : start

  task automatic stop;
    sda_low_out = 1'b1;
    #Q scl_out = 1'b1;
    #(2*Q) sda_low_out = 1'b0;
    #(4*Q);
  endtask : stop

  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(~b[i], s);
    end
    clk_bit(1'b0, s);
    ack = ~s;
  endtask : wbyte

  // Last byte of a read is refused so the target lets go of data
  task automatic rbyte(input logic nak, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(1'b0, s);
      b[i] = s;
    end
    clk_bit(~nak, s);
  endtask : rbyte
endmodule : scpm_host

/* File: tb/testbench.sv */
// Self-checking bench of the SMBus mode port
`timescale 1ns/10ps
`include "scpm_regs.svh"
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin errors++; $display("BAD %s exp %h got %h", n, e, g); end end
module testbench;
  logic       ref_clk, sys_rst, pg, ack;
  logic [1:0] bw_strap, sa_lo, sa_hi;
  logic [7:0] d, dev_ad;
  wire        scl, h_low, oe, dout, byp, eng, wide, narrow, pdn;
  wire        sda = !(h_low || (oe && !dout));
  int         errors = 0, check_count = 0, cyc = 0;

  scpm_host h (.sda_in(sda), .scl_out(scl), .sda_low_out(h_low));
  scpm_port i_dut (.ref_clk_in(ref_clk), .sys_rst_in(sys_rst), .scl_clk_in(scl), .serial_data_pin_in(sda),
    .serial_data_pin_out(dout), .serial_data_pin_oe_out(oe), .power_good_input_in(pg),
    .pll_bandwidth_strap_in(bw_strap), .address_strap_low_in(sa_lo), .address_strap_high_in(sa_hi),
    .freq_select_strap_in(1'b1), .pll_bypass_out(byp), .pll_engage_out(eng), .wide_loop_mode_out(wide),
    .narrow_loop_mode_out(narrow), .power_down_n_out(pdn));

  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      close_out;
    end
  end

  // ==========================================================
  // Bus transfers
  task automatic wr(input logic [7:0] cmd, input logic [7:0] v);
    h.start;
    h.wbyte(dev_ad, ack);
    h.wbyte(cmd, ack);
    h.wbyte(v, ack);
    `CHK("write ack", 1'b1, ack)
    h.stop;
  endtask : wr

  task automatic rd(input logic [7:0] cmd, output logic [7:0] v);
    h.start;
    h.wbyte(dev_ad, ack);
    h.wbyte(cmd, ack);
    h.start;
    h.wbyte(dev_ad | 8'h01, ack);
    h.rbyte(1'b1, v);
    h.stop;
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic t_override;
    `CHK("bypass", 1'b1, byp)
    `CHK("engage", 1'b0, eng)
    rd(8'h80, d);
    `CHK("byte0", 8'h43, d)
    wr(8'h80, 8'h06);
    rd(8'h80, d);
    `CHK("locked ovr", 8'h43, d)
    wr(8'h80, 8'h08);
    wr(8'h80, 8'h0E);
    `CHK("wide", 1'b1, wide)
    `CHK("engage", 1'b1, eng)
    rd(8'h80, d);
    `CHK("readback", 8'h4F, d)
    wr(8'h80, 8'h08);
    `CHK("narrow", 1'b1, narrow)
    wr(8'h80, 8'h0A);
    `CHK("bypass", 1'b1, byp)
    $display("override done");
  endtask : t_override

  task automatic t_block;
    logic [7:0] exp [8] = '{8'h4B, 8'hA1, 8'hB2, 8'hC3, 8'h00, 8'h00, 8'h00, 8'h00};
    h.start;
    h.wbyte(dev_ad, ack);
    h.wbyte(8'h01, ack);
    h.wbyte(8'h03, ack);
    for (int i = 1; i < 4; i++) begin
      h.wbyte(exp[i], ack);
      `CHK("block ack", 1'b1, ack)
    end
    h.stop;
    h.start;
    h.wbyte(dev_ad, ack);
    h.wbyte(8'h00, ack);
    h.start;
    h.wbyte(dev_ad | 8'h01, ack);
    h.rbyte(1'b0, d);
    `CHK("count", `SCPM_BLOCK_RD_COUNT, d)
    // Host takes every byte that the count announces
    for (int i = 0; i < `SCPM_BLOCK_RD_COUNT; i++) begin
      h.rbyte(i == `SCPM_BLOCK_RD_COUNT - 1, d);
      `CHK("block data", exp[i], d)
    end
    h.stop;
    $display("block done");
  endtask : t_block

  task automatic t_refuse;
    logic [7:0] bad [2] = '{8'h00, `SCPM_ADDR_LM};
    for (int i = 0; i < 2; i++) begin
      h.start;
      h.wbyte(bad[i], ack);
      `CHK("no ack", 1'b0, ack)
      h.stop;
    end
    $display("refuse done");
  endtask : t_refuse

  task automatic t_pdown;
    @(posedge ref_clk) pg <= 1'b0;
    repeat (30) @(posedge ref_clk);
    `CHK("pdn", 1'b0, pdn)
    `CHK("oe", 1'b0, oe)
    `CHK("dout", 1'b0, dout)
    pg <= 1'b1;
    repeat (30) @(posedge ref_clk);
    rd(8'h81, d);
    `CHK("kept", 8'hA1, d)
    $display("power down done");
  endtask : t_pdown

  // Mid-run reset with new straps; also the warm reset after the override change
  task automatic t_restrap;
    @(posedge ref_clk);
    sys_rst  <= 1'b1;
    pg       <= 1'b0;
    bw_strap <= `SCPM_LVL_HIGH;
    sa_hi    <= `SCPM_LVL_MID;
    sa_lo    <= `SCPM_LVL_HIGH;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pg <= 1'b1;
    repeat (40) @(posedge ref_clk);
    `CHK("wide", 1'b1, wide)
    `CHK("narrow", 1'b0, narrow)
    `CHK("engage", 1'b1, eng)
    h.start;
    h.wbyte(dev_ad, ack);
    `CHK("old addr", 1'b0, ack)
    h.stop;
    dev_ad = `SCPM_ADDR_MH;
    rd(8'h80, d);
    `CHK("byte0 wide", 8'hC7, d)
    wr(8'h80, 8'h08);
    wr(8'h80, 8'h08);
    `CHK("narrow ovr", 1'b1, narrow)
    rd(8'h80, d);
    `CHK("strap kept", 8'hC9, d)
    $display("restrap done");
  endtask : t_restrap

  task automatic close_out;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out

  initial begin
    ref_clk = 1'b0;
    sys_rst = 1'b1;
    pg = 1'b0;
    bw_strap = `SCPM_LVL_MID;
    sa_lo = `SCPM_LVL_LOW;
    sa_hi = `SCPM_LVL_LOW;
    dev_ad = `SCPM_ADDR_LL;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge ref_clk);
    pg <= 1'b1;
    repeat (40) @(posedge ref_clk);
    `CHK("pdn", 1'b1, pdn)
    t_override;
    t_block;
    t_refuse;
    t_pdown;
    t_restrap;
    close_out;
  end
endmodule : testbench
